/* dcc_defs.svh */
// Notes on behaviour
// - compare selected analog pin against reference and report above or below
// - comparator works only in active and subactive modes, halted otherwise
// - control bits 0 and 1 select input: 00 first, 01 second, 1x unused
// - run bit 3 set makes both pins analog and starts; clear restores digital
// - while running neither shared pin acts as an ordinary port input
// - control register is write-only at 018 hex with three implemented bits
// - control register clears on reset and on stop mode entry
// - result register is read-only at 017 hex, bits 0 and 1
// - during comparison the selected input's outcome loads its own result bit
// - unselected result bit may hold any value during comparison
// - result bits need not be kept once run is cleared
// - each result bit readable alone by a bit test on the result address
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH
`define DCC_ADDR_CONTROL  10'h018
`define DCC_ADDR_RESULT   10'h017
`define DCC_BIT_SEL_LO    0
`define DCC_BIT_SEL_HI    1
`define DCC_BIT_RUN       3
`define DCC_CONTROL_RESET 4'h0
`endif

/* dcc_pkg.sv */
package dcc_pkg;
    // power modes of the host controller, one-hot
    typedef enum logic [2:0] {
        DCC_PM_ACTIVE    = 3'b001,
        DCC_PM_SUBACTIVE = 3'b010,
        DCC_PM_OTHER     = 3'b100
    } dcc_pmode_t;
    // comparator run state, one-hot
    typedef enum logic [1:0] {
        DCC_ST_IDLE = 2'b01,
        DCC_ST_RUN  = 2'b10
    } dcc_state_t;
endpackage

/* dcc_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser for the asynchronous comparator outputs
module dcc_sync (
    input  wire logic       i_clk,   // system clock
    input  wire logic       i_ce,    // clock enable
    input  wire logic [1:0] i_async, // raw comparator levels
    output logic      [1:0] o_sync   // synchronised levels
);
    logic [1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // dcc_sync

/* dcc_top.sv */
`timescale 1ns/10ps
`include "dcc_defs.svh"
module dcc_top (
    input  wire logic       i_clk,        // system clock, 40 MHz
    input  wire logic       i_rst,        // synchronous reset, active high
    input  wire logic       i_ce,         // clock enable, freezes all state
    input  wire logic [2:0] i_pmode,      // one-hot power mode
    input  wire logic       i_stop_entry, // pulse on stop mode entry
    input  wire logic [9:0] i_addr,       // register address
    input  wire logic       i_wr,         // write strobe
    input  wire logic [3:0] i_wdata,      // write data
    input  wire logic       i_rd,         // read strobe
    output logic      [3:0] o_rdata,      // read data, held from last read
    input  wire logic       i_cmp_a,      // comparator level, input a above ref
    input  wire logic       i_cmp_b,      // comparator level, input b above ref
    input  wire logic       i_pin_a,      // port pin a digital level
    input  wire logic       i_pin_b,      // port pin b digital level
    output logic            o_analog_en,  // both shared pins in analog mode
    output logic            o_cmp_en,     // analog comparator enabled
    output logic      [1:0] o_port_in     // digital port levels, 0 when analog
);
    // control, result and state registers with their next values
    logic [3:0]          ctrl_r;
    logic [3:0]          ctrl_nxt;
    logic [1:0]          result_r;
    logic [1:0]          result_nxt;
    logic [1:0]          pins_m_r;
    logic [1:0]          pins_s_r;
    logic [1:0]          cmp_s;
    dcc_pkg::dcc_state_t state_r;
    dcc_pkg::dcc_state_t state_nxt;

    // address decode and power mode qualification
    // full ten-bit compare, so aliases of the two addresses are ignored
    wire wr_ctrl  = i_wr && (i_addr == `DCC_ADDR_CONTROL);
    wire rd_res   = i_rd && (i_addr == `DCC_ADDR_RESULT);
    wire pm_ok    = (i_pmode == dcc_pkg::DCC_PM_ACTIVE)
                  || (i_pmode == dcc_pkg::DCC_PM_SUBACTIVE);
    wire run      = ctrl_r[`DCC_BIT_RUN];
    wire sel_hi   = ctrl_r[`DCC_BIT_SEL_HI];
    wire sel_lo   = ctrl_r[`DCC_BIT_SEL_LO];
    wire active   = (state_r == dcc_pkg::DCC_ST_RUN) && pm_ok;

    // bit 2 of the write data is dropped, so the unused position stores nothing
    assign ctrl_nxt = (i_stop_entry) ? `DCC_CONTROL_RESET :
                      (wr_ctrl) ? {i_wdata[`DCC_BIT_RUN], 1'b0,
                                   i_wdata[`DCC_BIT_SEL_HI],
                                   i_wdata[`DCC_BIT_SEL_LO]} : ctrl_r;
    // state follows the run bit one cycle later, so the first load after a
    // start sees a synchroniser that has had a cycle to settle
    assign state_nxt = run ? dcc_pkg::DCC_ST_RUN : dcc_pkg::DCC_ST_IDLE;

    // only the selected input's bit loads; 1x selects nothing
    // the unselected bit keeps whatever it held, which the rules allow
    always_comb begin
        result_nxt = result_r;
        if (!run) begin
            result_nxt = 2'h0;
        end else if (active && !sel_hi) begin
            if (sel_lo) begin
                result_nxt[1] = cmp_s[1];
            end else begin
                result_nxt[0] = cmp_s[0];
            end
        end
    end

    // comparator levels come from the analog side and are asynchronous here
    dcc_sync u_cmp_sync (
        .i_clk   (i_clk),
        .i_ce    (i_ce),
        .i_async ({i_cmp_b, i_cmp_a}),
        .o_sync  (cmp_s)
    );

    // pins are synchronised before being offered as port inputs
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            pins_m_r <= {i_pin_b, i_pin_a};
            pins_s_r <= pins_m_r;
        end
    end

    // control, state and result registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_r   <= `DCC_CONTROL_RESET;
            state_r  <= dcc_pkg::DCC_ST_IDLE;
            result_r <= 2'h0;
        end else if (i_ce) begin
            ctrl_r   <= ctrl_nxt;
            state_r  <= state_nxt;
            result_r <= result_nxt;
        end
    end

    // outputs straight from flops; port inputs blocked while analog
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata     <= 4'h0;
            o_analog_en <= 1'b0;
            o_cmp_en    <= 1'b0;
            o_port_in   <= 2'h0;
        end else if (i_ce) begin
            if (rd_res) begin
                o_rdata <= {2'h0, result_r};
            end
            o_analog_en <= ctrl_nxt[`DCC_BIT_RUN];
            o_cmp_en    <= ctrl_nxt[`DCC_BIT_RUN] && pm_ok;
            o_port_in   <= ctrl_nxt[`DCC_BIT_RUN] ? 2'h0 : pins_s_r;
        end
    end

    // a stop entry always leaves the comparator off and pins digital
    stop_clears_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_stop_entry) |=> (!o_analog_en && !run))
        else $error("stop entry did not clear control");

    // the pin mux must never leak a digital level while the pins are analog
    pins_blocked_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_analog_en |-> (o_port_in == 2'h0))
        else $error("port input seen while analog");

    // analog mode follows the run bit of every accepted write
    run_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && wr_ctrl && !i_stop_entry) |=> (o_analog_en == $past(i_wdata[3])))
        else $error("analog mode does not follow run write");

    // outside active and subactive the comparator must be off
    halted_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !pm_ok) |=> !o_cmp_en)
        else $error("comparator enabled in halted mode");

    // input a selected: its bit takes the synchronised level
    load_sel_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && active && run && ctrl_r[1:0] == 2'h0) |=> (result_r[0] == $past(cmp_s[0])))
        else $error("selected result bit not loaded");

    // bit 2 has no storage behind it
    bit2_unused_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ctrl_r[2] == 1'b0)
        else $error("unused control bit stored");

    // a read returns the result register as it stood at the read edge
    read_back_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && rd_res) |=> (o_rdata[1:0] == $past(result_r)))
        else $error("result read mismatch");

    // a 1x selection points at no input, so nothing may load
    unused_sel_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && run && sel_hi) |=> (result_r == $past(result_r)))
        else $error("unused selection loaded a result");

    // reset must leave control clear and the comparator off
    reset_clears_a: assert property (@(posedge i_clk)
        i_rst |=> (ctrl_r == `DCC_CONTROL_RESET && !o_analog_en && !o_cmp_en))
        else $error("reset did not clear control");

    // a stop entry wins over a write in the same cycle
    stop_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && i_stop_entry && wr_ctrl) |=> (ctrl_r == `DCC_CONTROL_RESET))
        else $error("write beat stop entry");

    // writes to any other address leave control alone
    other_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !wr_ctrl && !i_stop_entry) |=> (ctrl_r == $past(ctrl_r)))
        else $error("control changed without a write");

    // comparator enable is the run bit gated by the power mode
    cmp_en_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce |=> (o_cmp_en == ($past(ctrl_nxt[`DCC_BIT_RUN]) && $past(pm_ok))))
        else $error("comparator enable wrong");

    // input b selected: its bit takes the synchronised level
    load_sel_b_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && active && ctrl_r[1:0] == 2'h1) |=> (result_r[1] == $past(cmp_s[1])))
        else $error("input b result not loaded");

    // with input a selected the bit of input b is left as it was
    unsel_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && active && ctrl_r[1:0] == 2'h0) |=> (result_r[1] == $past(result_r[1])))
        else $error("unselected result bit changed");

    // results are dropped once the run bit is clear
    idle_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !run) |=> (result_r == 2'h0))
        else $error("result kept while idle");

    // a halted comparator must not update the result
    halted_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && run && !pm_ok) |=> (result_r == $past(result_r)))
        else $error("result loaded in halted mode");

    // read data stands until the next result read
    rdata_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!rd_res || !i_ce) |=> (o_rdata == $past(o_rdata)))
        else $error("read data changed without a read");

    // unused result positions read as zero in this build
    rdata_upper_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rdata[3:2] == 2'h0)
        else $error("unused result bits not zero");

    // with run clear the pins are plain digital inputs again
    port_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !ctrl_nxt[`DCC_BIT_RUN]) |=> (o_port_in == $past(pins_s_r)))
        else $error("port input not passed through");

    // the state register tracks a set run bit
    state_run_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && run) |=> (state_r == dcc_pkg::DCC_ST_RUN))
        else $error("state did not follow run");

    // the one-hot state must never hold two or no bits
    state_onehot_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $onehot(state_r))
        else $error("state not one-hot");

    // a low enable freezes control and the pin mode
    ce_freeze_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_ce |=> (ctrl_r == $past(ctrl_r) && o_analog_en == $past(o_analog_en)))
        else $error("state moved with enable low");

    // the comparator is never on while the pins are digital
    cmp_analog_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_cmp_en |-> o_analog_en)
        else $error("comparator on with digital pins");
endmodule // dcc_top

/* dcc_top_tb.sv */
`timescale 1ns/10ps
`include "dcc_defs.svh"
module dcc_top_tb;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_ce = 1'b1;
    logic [2:0] i_pmode = dcc_pkg::DCC_PM_ACTIVE;
    logic       i_stop_entry = 1'b0;
    logic [9:0] i_addr = 10'h000;
    logic       i_wr = 1'b0;
    logic [3:0] i_wdata = 4'h0;
    logic       i_rd = 1'b0;
    logic [3:0] o_rdata;
    logic       i_cmp_a = 1'b0;
    logic       i_cmp_b = 1'b0;
    logic       i_pin_a = 1'b0;
    logic       i_pin_b = 1'b1;
    logic       o_analog_en;
    logic       o_cmp_en;
    logic [1:0] o_port_in;
    int         mismatches = 0;
    int         total_checks = 0;
    // 40 MHz system clock
    always #12.5 i_clk = ~i_clk;
    dcc_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_pmode(i_pmode),
        .i_stop_entry(i_stop_entry), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_a(i_cmp_a), .i_cmp_b(i_cmp_b),
        .i_pin_a(i_pin_a), .i_pin_b(i_pin_b), .o_analog_en(o_analog_en),
        .o_cmp_en(o_cmp_en), .o_port_in(o_port_in));
    // compare against four-state values so an unknown never matches
    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // wait n edges, then step off the edge so registered outputs have landed
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [3:0] d);
        @(posedge i_clk);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        w(2);
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge i_clk);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        w(2);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // the whole sequence needs a few microseconds; this cuts a hang short
    initial begin
        #50000;
        mismatches++;
        summarize();
    end
    initial begin
        w(3);
        i_rst <= 1'b0;
        w(6);
        chk("analog_en", 4'h0, {3'h0, o_analog_en});
        chk("port_in idle", 4'h2, {2'h0, o_port_in});
        // each input, both outcomes; wait for the synchroniser before reading
        for (int s = 0; s < 2; s++) begin
            for (int v = 1; v >= 0; v--) begin
                wr(`DCC_ADDR_CONTROL, 4'h8 | 4'(s));
                if (s == 0) i_cmp_a <= v[0]; else i_cmp_b <= v[0];
                w(6);
                rd(`DCC_ADDR_RESULT);
                chk("result bit", 4'(v), {3'h0, o_rdata[s]});
            end
        end
        chk("analog_en run", 4'h1, {3'h0, o_analog_en});
        chk("port_in run", 4'h0, {2'h0, o_port_in});
        wr(`DCC_ADDR_CONTROL, 4'hc);
        i_cmp_a <= 1'b1;
        w(6);
        rd(`DCC_ADDR_RESULT);
        chk("bit2 ignored", 4'h1, {3'h0, o_rdata[0]});
        chk("rdata upper", 4'h0, {2'h0, o_rdata[3:2]});
        wr(10'h016, 4'h0);
        wr(`DCC_ADDR_RESULT, 4'h0);
        chk("other addr", 4'h1, {3'h0, o_analog_en});
        wr(`DCC_ADDR_CONTROL, 4'ha);
        chk("sel unused", 4'h1, {3'h0, o_analog_en});
        i_pmode <= dcc_pkg::DCC_PM_SUBACTIVE;
        w(3);
        chk("cmp_en sub", 4'h1, {3'h0, o_cmp_en});
        i_pmode <= dcc_pkg::DCC_PM_OTHER;
        w(3);
        chk("cmp_en other", 4'h0, {3'h0, o_cmp_en});
        i_pmode <= dcc_pkg::DCC_PM_ACTIVE;
        @(posedge i_clk);
        i_stop_entry <= 1'b1;
        @(posedge i_clk);
        i_stop_entry <= 1'b0;
        w(6);
        chk("stop clears", 4'h0, {3'h0, o_analog_en});
        chk("port_in back", 4'h2, {2'h0, o_port_in});
        wr(`DCC_ADDR_CONTROL, 4'h8);
        wr(`DCC_ADDR_CONTROL, 4'h0);
        chk("run off", 4'h0, {3'h0, o_cmp_en});
        wr(`DCC_ADDR_CONTROL, 4'h8);
        i_rst <= 1'b1;
        w(2);
        i_rst <= 1'b0;
        w(1);
        chk("reset mid run", 4'h0, {3'h0, o_analog_en});
        summarize();
    end
endmodule // dcc_top_tb
